// ### logic/pdc_pkg.sv
// constants, register map and carrier types for the pll divider configuration block
`default_nettype none
package pdc_pkg;
    // register offsets on the control port
    localparam logic [7:0] OFS_REF_GPIO_SEL = 8'h12;
    localparam logic [7:0] OFS_P_DIVIDER    = 8'h14;
    localparam logic [7:0] OFS_J_MULT       = 8'h15;
    localparam logic [7:0] OFS_D_FRAC_HIGH  = 8'h16;
    localparam logic [7:0] OFS_D_FRAC_LOW   = 8'h17;
    localparam logic [7:0] OFS_R_MULT       = 8'h18;
    localparam logic [7:0] OFS_DSP_CLK_DIV  = 8'h1B;

    // field widths and positions (all fields sit at bit 0)
    localparam int REF_SEL_W  = 3;
    localparam int PRE_DIV_W  = 4;
    localparam int INT_MULT_W = 6;
    localparam int FRAC_HI_W  = 6;
    localparam int FRAC_LO_W  = 8;
    localparam int FRAC_W     = 14;
    localparam int POST_MUL_W = 4;
    localparam int DSP_DIV_W  = 7;
    localparam int FIELD_LSB  = 0;

    // values after reset
    localparam logic [7:0] RST_REF_GPIO_SEL = 8'h00;
    localparam logic [7:0] RST_P_DIVIDER    = 8'h00;
    localparam logic [7:0] RST_J_MULT       = 8'h08;
    localparam logic [7:0] RST_D_FRAC_HIGH  = 8'h00;
    localparam logic [7:0] RST_D_FRAC_LOW   = 8'h00;
    localparam logic [7:0] RST_R_MULT       = 8'h00;
    localparam logic [7:0] RST_DSP_CLK_DIV  = 8'h00;

    // reference pin selector codes
    localparam logic [2:0] REF_SEL_PIN_ZERO = 3'h3;
    localparam logic [2:0] REF_SEL_PIN_TWO  = 3'h5;

    // prohibited codes and limits
    localparam logic [3:0]  PRE_DIV_BAD  = 4'hF;
    localparam logic [5:0]  INT_MULT_BAD = 6'h00;
    localparam logic [13:0] FRAC_MAX     = 14'h270F;
    localparam logic [23:0] FRAC_SCALE   = 24'h002710;

    // effective pll setting as applied to the analog core
    typedef struct packed {
        logic [4:0]  p;     // pre-divider, 1..15
        logic [5:0]  j;     // integer multiplier, 1..63
        logic [13:0] d;     // fraction in ten-thousandths
        logic [4:0]  r;     // multiplier, 1..16
    } pdc_pll_cfg_t;

    // raw codes delivered by the automatic clock configuration logic
    typedef struct packed {
        logic [3:0] p_code;
        logic [5:0] j_code;
        logic [13:0] d;
        logic [3:0] r_code;
        logic [6:0] dsp_code;
    } pdc_auto_t;
endpackage : pdc_pkg
`default_nettype wire

// ### logic/pdc_dsp_div.sv
// enable-pulse divider for the dsp clock, divides source pulses by code plus one
`default_nettype none
module pdc_dsp_div #(
    parameter int WIDTH = 7
) (
    input  wire logic             clk,     // system clock
    input  wire logic             rst,     // synchronous reset, high
    input  wire logic             src_en,  // one pulse per source clock
    input  wire logic [WIDTH-1:0] div,     // divide code, ratio is code plus one
    output logic                  tick     // one pulse per divided period
);
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic             tick;
    } pdc_div_st_t;

    pdc_div_st_t st_r;
    pdc_div_st_t st_nxt;

    initial begin
        if (WIDTH < 1 || WIDTH > 16) $error("pdc_dsp_div: WIDTH out of range");
    end

    // count source pulses, a code lowered below the count wraps at once
    always_comb begin
        st_nxt      = st_r;
        st_nxt.tick = 1'b0;
        if (src_en) begin
            if (st_r.cnt >= div) begin
                st_nxt.cnt  = '0;
                st_nxt.tick = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt + WIDTH'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;

    // with code zero, each source pulse gives a pulse out on the next edge
    a_div_period: assert property (@(posedge clk) disable iff (rst)
        (src_en && st_r.cnt == '0 && div == '0) |=> tick) // RULE12
        else $error("divide-by-one did not pass the source pulse");
endmodule : pdc_dsp_div
`default_nettype wire

// ### logic/pdc_pll_config.sv
// pll reference pin select, p/j/d/r settings and dsp clock divider registers
// Function
// RULE1 - select 011 pin zero, 101 pin two, else mute
// RULE2 - pre-divider P equals code plus one
// RULE3 - software never writes pre-divider code 1111
// RULE4 - integer multiplier J taken directly, 1 to 63
// RULE5 - software never writes J code zero
// RULE6 - total factor is J.D times R
// RULE7 - D split six high, eight low bits
// RULE8 - software keeps D within 0 to 9999
// RULE9 - multiplier R equals code plus one
// RULE10 - auto mode ignores programmed P, J, D, R
// RULE11 - dsp divider seven bits, bit seven reserved
// RULE12 - dsp divide by code plus one, auto ignores
// RULE13 - new D applied after both halves written
`default_nettype none
module pdc_pll_config #(
    parameter int DSP_W = pdc_pkg::DSP_DIV_W
) (
    input  wire logic                 SYS_CLK,       // system clock, 40 MHz
    input  wire logic                 RST,           // synchronous reset, high
    input  wire logic                 REG_WR,        // register write strobe
    input  wire logic                 REG_RD,        // register read strobe
    input  wire logic [7:0]           REG_ADDR,      // register offset
    input  wire logic [7:0]           REG_WDATA,     // write data
    output logic      [7:0]           REG_RDATA,     // read data, next cycle
    input  wire logic                 AUTO_MODE,     // automatic clock config active
    input  wire pdc_pkg::pdc_auto_t   AUTO_CFG,      // settings chosen in auto mode
    input  wire logic                 GEN_PIN_ZERO,  // gpio pin zero level
    input  wire logic                 GEN_PIN_TWO,   // gpio pin two level
    output logic                      PLL_REF_GPIO,  // selected gpio reference
    output logic                      PLL_REF_MUTE,  // reference path muted
    output pdc_pkg::pdc_pll_cfg_t     PLL_CFG,       // effective p, j, d, r
    output logic      [23:0]          PLL_MULT_X10K, // J.D*R in ten-thousandths
    output logic                      CFG_ILLEGAL,   // a prohibited code is applied
    input  wire logic                 DSP_SRC_EN,    // dsp source clock pulse
    output logic                      DSP_CLK_EN     // divided dsp clock pulse
);
    typedef struct packed {
        logic [2:0]        ref_sel;
        logic [3:0]        pre_div;
        logic [5:0]        int_mult;
        logic [5:0]        frac_hi;
        logic [7:0]        frac_lo;
        logic              hi_seen;
        logic              lo_seen;
        logic [13:0]       frac_act;
        logic [3:0]        post_mult;
        logic [DSP_W-1:0]  dsp_div;
        logic [DSP_W-1:0]  dsp_eff;
        logic [7:0]        rdata;
        logic              ref_gpio;
        logic              ref_mute;
        pdc_pkg::pdc_pll_cfg_t cfg;
        logic [23:0]       mult;
        logic              illegal;
    } pdc_state_t;

    pdc_state_t st_r;
    pdc_state_t st_nxt;
    logic       dsp_tick;

    initial begin
        if (DSP_W != pdc_pkg::DSP_DIV_W) $error("pdc_pll_config: DSP_W must be 7");
    end

    // selector decode, shared by the pin mux and its check
    function automatic logic [1:0] ref_decode(input logic [2:0] sel);
        unique case (sel)
            pdc_pkg::REF_SEL_PIN_ZERO: ref_decode = 2'h1;
            pdc_pkg::REF_SEL_PIN_TWO:  ref_decode = 2'h2;
            default:                   ref_decode = 2'h0;
        endcase
    endfunction : ref_decode

    // register image on read, reserved bits zero
    function automatic logic [7:0] read_reg(input pdc_state_t s, input logic [7:0] a);
        unique case (a)
            pdc_pkg::OFS_REF_GPIO_SEL: read_reg = {5'h00, s.ref_sel};
            pdc_pkg::OFS_P_DIVIDER:    read_reg = {4'h0, s.pre_div};
            pdc_pkg::OFS_J_MULT:       read_reg = {2'h0, s.int_mult};
            pdc_pkg::OFS_D_FRAC_HIGH:  read_reg = {2'h0, s.frac_hi};
            pdc_pkg::OFS_D_FRAC_LOW:   read_reg = s.frac_lo;
            pdc_pkg::OFS_R_MULT:       read_reg = {4'h0, s.post_mult};
            pdc_pkg::OFS_DSP_CLK_DIV:  read_reg = {1'h0, s.dsp_div};
            default:                   read_reg = 8'h00;
        endcase
    endfunction : read_reg

    // register writes, fraction commit and effective settings
    always_comb begin
        logic [3:0]  p_code;
        logic [5:0]  j_code;
        logic [13:0] d_val;
        logic [3:0]  r_code;
        logic [1:0]  pin;
        logic        hi_now;
        logic        lo_now;
        logic [23:0] jd;
        p_code = '0;
        j_code = '0;
        d_val  = '0;
        r_code = '0;
        pin    = '0;
        hi_now = 1'b0;
        lo_now = 1'b0;
        jd     = '0;
        st_nxt = st_r;
        if (REG_WR) begin
            unique case (REG_ADDR)
                pdc_pkg::OFS_REF_GPIO_SEL: st_nxt.ref_sel   = REG_WDATA[2:0];
                pdc_pkg::OFS_P_DIVIDER:    st_nxt.pre_div   = REG_WDATA[3:0];
                pdc_pkg::OFS_J_MULT:       st_nxt.int_mult  = REG_WDATA[5:0];
                pdc_pkg::OFS_D_FRAC_HIGH: begin
                    st_nxt.frac_hi = REG_WDATA[5:0]; // RULE7
                    hi_now         = 1'b1;
                end
                pdc_pkg::OFS_D_FRAC_LOW: begin
                    st_nxt.frac_lo = REG_WDATA; // RULE7
                    lo_now         = 1'b1;
                end
                pdc_pkg::OFS_R_MULT:       st_nxt.post_mult = REG_WDATA[3:0];
                pdc_pkg::OFS_DSP_CLK_DIV:  st_nxt.dsp_div   = REG_WDATA[6:0]; // RULE11
                default: ;
            endcase
        end
        // hold the fraction back until both halves are in, order free
        if ((st_r.hi_seen || hi_now) && (st_r.lo_seen || lo_now)) begin
            st_nxt.frac_act = {st_nxt.frac_hi, st_nxt.frac_lo}; // RULE13
            st_nxt.hi_seen  = 1'b0;
            st_nxt.lo_seen  = 1'b0;
        end else begin
            st_nxt.hi_seen = st_r.hi_seen || hi_now;
            st_nxt.lo_seen = st_r.lo_seen || lo_now;
        end
        // read data is held until the next read
        if (REG_RD) begin
            st_nxt.rdata = read_reg(st_r, REG_ADDR);
        end
        // reference pin mux, unused codes mute the path
        pin             = ref_decode(st_r.ref_sel);
        st_nxt.ref_mute = (pin == 2'h0); // RULE1
        st_nxt.ref_gpio = (pin == 2'h1) ? GEN_PIN_ZERO :
                          (pin == 2'h2) ? GEN_PIN_TWO : 1'b0; // RULE1
        // auto mode takes every factor from the auto logic
        if (AUTO_MODE) begin
            p_code         = AUTO_CFG.p_code; // RULE10
            j_code         = AUTO_CFG.j_code;
            d_val          = AUTO_CFG.d;
            r_code         = AUTO_CFG.r_code;
            st_nxt.dsp_eff = AUTO_CFG.dsp_code; // RULE12
        end else begin
            p_code         = st_r.pre_div;
            j_code         = st_r.int_mult;
            d_val          = st_r.frac_act;
            r_code         = st_r.post_mult;
            st_nxt.dsp_eff = st_r.dsp_div; // RULE12
        end
        st_nxt.cfg.p = {1'b0, p_code} + 5'h01; // RULE2
        st_nxt.cfg.j = j_code; // RULE4
        st_nxt.cfg.d = d_val;
        st_nxt.cfg.r = {1'b0, r_code} + 5'h01; // RULE9
        // 63.9999 * 16 still fits in 24 bits
        jd          = 24'(j_code) * pdc_pkg::FRAC_SCALE + 24'(d_val);
        st_nxt.mult = 24'(jd * 24'({1'b0, r_code} + 5'h01)); // RULE6
        // flags a setting software was told never to use
        st_nxt.illegal = (p_code == pdc_pkg::PRE_DIV_BAD)
                       || (j_code == pdc_pkg::INT_MULT_BAD)
                       || (d_val > pdc_pkg::FRAC_MAX); // RULE3 RULE5 RULE8
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            st_r           <= '0;
            st_r.ref_sel   <= pdc_pkg::RST_REF_GPIO_SEL[2:0];
            st_r.pre_div   <= pdc_pkg::RST_P_DIVIDER[3:0];
            st_r.int_mult  <= pdc_pkg::RST_J_MULT[5:0];
            st_r.frac_hi   <= pdc_pkg::RST_D_FRAC_HIGH[5:0];
            st_r.frac_lo   <= pdc_pkg::RST_D_FRAC_LOW;
            st_r.post_mult <= pdc_pkg::RST_R_MULT[3:0];
            st_r.dsp_div   <= pdc_pkg::RST_DSP_CLK_DIV[6:0];
            st_r.ref_mute  <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // dsp clock divider on source pulses
    pdc_dsp_div #(
        .WIDTH (DSP_W)
    ) u_dsp_div (
        .clk    (SYS_CLK),
        .rst    (RST),
        .src_en (DSP_SRC_EN),
        .div    (st_r.dsp_eff),
        .tick   (dsp_tick)
    );

    // outputs straight from flops
    assign REG_RDATA     = st_r.rdata;
    assign PLL_REF_GPIO  = st_r.ref_gpio;
    assign PLL_REF_MUTE  = st_r.ref_mute;
    assign PLL_CFG       = st_r.cfg;
    assign PLL_MULT_X10K = st_r.mult;
    assign CFG_ILLEGAL   = st_r.illegal;
    assign DSP_CLK_EN    = dsp_tick;

    // fraction write sequences
    sequence s_hi_wr;
        REG_WR && REG_ADDR == pdc_pkg::OFS_D_FRAC_HIGH;
    endsequence
    sequence s_lo_wr;
        REG_WR && REG_ADDR == pdc_pkg::OFS_D_FRAC_LOW;
    endsequence

    a_frac_commit: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE13
        (s_lo_wr and (st_r.hi_seen && !st_r.lo_seen))
        |=> st_r.frac_act == $past(({st_r.frac_hi, REG_WDATA}))) // RULE7
        else $error("fraction not committed after both halves");
    a_frac_hold: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE13
        (s_hi_wr and !st_r.lo_seen and !st_r.hi_seen) |=> $stable(st_r.frac_act))
        else $error("fraction changed after only the high half");
    a_ref_mute: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE1
        (ref_decode(st_r.ref_sel) == 2'h0) |=> PLL_REF_MUTE && !PLL_REF_GPIO)
        else $error("reserved selector did not mute reference");
    a_ref_pin: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE1
        (st_r.ref_sel == pdc_pkg::REF_SEL_PIN_TWO) |=> PLL_REF_GPIO == $past(GEN_PIN_TWO))
        else $error("pin two not routed to reference");
    a_p_factor: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE2
        !AUTO_MODE |=> PLL_CFG.p == 5'($past(st_r.pre_div)) + 5'h01)
        else $error("pre-divider not code plus one");
    a_j_factor: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE4
        !AUTO_MODE |=> PLL_CFG.j == $past(st_r.int_mult))
        else $error("integer multiplier not taken directly");
    a_r_factor: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE9
        !AUTO_MODE |=> PLL_CFG.r == 5'($past(st_r.post_mult)) + 5'h01)
        else $error("multiplier R not code plus one");
    a_mult_total: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE6
        PLL_MULT_X10K == 24'((24'(PLL_CFG.j) * 24'h002710 + 24'(PLL_CFG.d))
                             * 24'(PLL_CFG.r)))
        else $error("total factor not J.D times R");
    a_auto_ignore: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE10
        AUTO_MODE |=> PLL_CFG.j == $past(AUTO_CFG.j_code) && PLL_CFG.d == $past(AUTO_CFG.d))
        else $error("auto mode used programmed values");
    a_dsp_reserved: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE11
        REG_RD && REG_ADDR == pdc_pkg::OFS_DSP_CLK_DIV |=> REG_RDATA[7] == 1'b0)
        else $error("dsp divider reserved bit read as one");
    a_dsp_auto: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE12
        AUTO_MODE |=> st_r.dsp_eff == $past(AUTO_CFG.dsp_code))
        else $error("dsp divider not ignored in auto mode");
    a_dsp_prog: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE12
        !AUTO_MODE |=> st_r.dsp_eff == $past(st_r.dsp_div))
        else $error("programmed dsp divider not applied");
    a_auto_pr: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE10
        AUTO_MODE |=> PLL_CFG.p == 5'($past(AUTO_CFG.p_code)) + 5'h01
                   && PLL_CFG.r == 5'($past(AUTO_CFG.r_code)) + 5'h01)
        else $error("auto mode p or r not taken from auto logic");
    a_ref_zero: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE1
        (st_r.ref_sel == pdc_pkg::REF_SEL_PIN_ZERO)
        |=> PLL_REF_GPIO == $past(GEN_PIN_ZERO) && !PLL_REF_MUTE)
        else $error("pin zero not routed to reference");

    // low half first, the high half then completes the pair
    a_frac_swap: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE13
        (s_hi_wr and (st_r.lo_seen && !st_r.hi_seen))
        |=> st_r.frac_act == $past(({REG_WDATA[5:0], st_r.frac_lo})))
        else $error("fraction not committed after low then high");
    a_frac_lo_hold: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE13
        (s_lo_wr and (!st_r.lo_seen && !st_r.hi_seen)) |=> $stable(st_r.frac_act))
        else $error("fraction changed after only the low half");

    // each programmed field lands on the edge that takes its write
    a_wr_sel: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE1
        REG_WR && REG_ADDR == pdc_pkg::OFS_REF_GPIO_SEL
        |=> st_r.ref_sel == $past(REG_WDATA[2:0]))
        else $error("reference selector write lost");
    a_wr_pre: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE2
        REG_WR && REG_ADDR == pdc_pkg::OFS_P_DIVIDER
        |=> st_r.pre_div == $past(REG_WDATA[3:0]))
        else $error("pre-divider write lost");
    a_wr_int: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE4
        REG_WR && REG_ADDR == pdc_pkg::OFS_J_MULT
        |=> st_r.int_mult == $past(REG_WDATA[5:0]))
        else $error("integer multiplier write lost");
    a_wr_post: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE9
        REG_WR && REG_ADDR == pdc_pkg::OFS_R_MULT
        |=> st_r.post_mult == $past(REG_WDATA[3:0]))
        else $error("multiplier R write lost");
    a_wr_dsp: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE11
        REG_WR && REG_ADDR == pdc_pkg::OFS_DSP_CLK_DIV
        |=> st_r.dsp_div == $past(REG_WDATA[6:0]))
        else $error("dsp divider write lost");

    // prohibited settings are stored, so the flag is the only warning
    a_bad_pre: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE3
        !AUTO_MODE && st_r.pre_div == pdc_pkg::PRE_DIV_BAD |=> CFG_ILLEGAL)
        else $error("pre-divider code 1111 not flagged");
    a_bad_int: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE5
        !AUTO_MODE && st_r.int_mult == pdc_pkg::INT_MULT_BAD |=> CFG_ILLEGAL)
        else $error("integer multiplier zero not flagged");
    a_bad_frac: assert property (@(posedge SYS_CLK) disable iff (RST) // RULE8
        !AUTO_MODE && st_r.frac_act > pdc_pkg::FRAC_MAX |=> CFG_ILLEGAL)
        else $error("fraction above range not flagged");
endmodule : pdc_pll_config
`default_nettype wire

// ### test/pdc_pll_config_tb.sv
// self-checking testbench for the pll divider configuration block
`default_nettype none
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("unexpected %s expected %h seen %h", nm, exp, got); end end
module pdc_pll_config_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic                   sys_clk, rst, reg_wr, reg_rd, auto_mode;
    logic [7:0]             reg_addr, reg_wdata, reg_rdata, rv;
    pdc_pkg::pdc_auto_t     auto_cfg;
    logic                   gen_pin_zero, gen_pin_two, pll_ref_gpio, pll_ref_mute;
    pdc_pkg::pdc_pll_cfg_t  pll_cfg;
    logic [23:0]            pll_mult_x10k;
    logic                   cfg_illegal, dsp_src_en, dsp_clk_en;
    int                     num_errors, checks, cycles, tick_cnt;
    logic [7:0]             addrs [7] = '{8'h12, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h1B};
    logic [7:0]             masks [7] = '{8'h07, 8'h0F, 8'h3F, 8'h3F, 8'hFF, 8'h0F, 8'h7F};

    pdc_pll_config pdc_pll_config_inst (
        .SYS_CLK(sys_clk), .RST(rst), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
        .AUTO_MODE(auto_mode), .AUTO_CFG(auto_cfg), .GEN_PIN_ZERO(gen_pin_zero),
        .GEN_PIN_TWO(gen_pin_two), .PLL_REF_GPIO(pll_ref_gpio), .PLL_REF_MUTE(pll_ref_mute),
        .PLL_CFG(pll_cfg), .PLL_MULT_X10K(pll_mult_x10k), .CFG_ILLEGAL(cfg_illegal),
        .DSP_SRC_EN(dsp_src_en), .DSP_CLK_EN(dsp_clk_en)
    );

    // 40 MHz system clock
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // cycle ceiling, generous against a run of under two thousand cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            print_verdict();
        end
    end
    // divided pulses counted for the divider windows
    always @(posedge sys_clk) if (dsp_clk_en === 1'b1) tick_cnt++;

    task automatic print_verdict();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict

    // one write cycle; the strobe drops on the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        #1 d = reg_rdata;
    endtask : rd
    // write effects reach the outputs one edge after the write edge
    task automatic settle();
        repeat (3) @(posedge sys_clk);
        #1;
    endtask : settle
    task automatic chk_cfg(input logic [4:0] p, input logic [5:0] j, input logic [13:0] d,
                           input logic [4:0] r, input logic bad);
        pdc_pkg::pdc_pll_cfg_t exp_cfg;
        logic [23:0]           m;
        exp_cfg = '{p: p, j: j, d: d, r: r};
        m = (24'(j) * pdc_pkg::FRAC_SCALE + 24'(d)) * 24'(r);
        `CHK("pll_cfg", exp_cfg, pll_cfg)
        `CHK("pll_mult_x10k", m, pll_mult_x10k)
        `CHK("cfg_illegal", bad, cfg_illegal)
    endtask : chk_cfg

    // reset values, reserved bits, unmapped offset
    task automatic test_regs();
        logic [7:0] rst_vals [7];
        rst_vals = '{pdc_pkg::RST_REF_GPIO_SEL, pdc_pkg::RST_P_DIVIDER, pdc_pkg::RST_J_MULT,
            pdc_pkg::RST_D_FRAC_HIGH, pdc_pkg::RST_D_FRAC_LOW, pdc_pkg::RST_R_MULT,
            pdc_pkg::RST_DSP_CLK_DIV};
        chk_cfg(5'h01, 6'h08, 14'h0000, 5'h01, 1'b0);
        `CHK("ref_mute", 1'b1, pll_ref_mute)
        for (int i = 0; i < 7; i++) begin
            rd(addrs[i], rv);
            `CHK("reset value", rst_vals[i], rv)
        end
        // all ones, then back to reset value; the low half is left staged
        for (int i = 0; i < 7; i++) begin
            wr(addrs[i], 8'hFF);
            rd(addrs[i], rv);
            `CHK("reserved bits", masks[i], rv)
            wr(addrs[i], rst_vals[i]);
        end
        wr(8'h13, 8'hFF);
        rd(8'h13, rv);
        `CHK("unmapped read", 8'h00, rv)
        // a last high write pairs the staged low half, so d commits as zero
        wr(pdc_pkg::OFS_D_FRAC_HIGH, 8'h00);
        settle();
        chk_cfg(5'h01, 6'h08, 14'h0000, 5'h01, 1'b0);
    endtask : test_regs

    // every selector code, with distinct pin levels
    task automatic test_ref_mux();
        @(posedge sys_clk);
        gen_pin_zero <= 1'b1;
        gen_pin_two <= 1'b0;
        for (int c = 0; c < 8; c++) begin
            wr(pdc_pkg::OFS_REF_GPIO_SEL, 8'(c));
            settle();
            `CHK("ref_mute", !(c == 3 || c == 5), pll_ref_mute)
            `CHK("ref_gpio", (c == 3), pll_ref_gpio)
        end
        wr(pdc_pkg::OFS_REF_GPIO_SEL, 8'h05);
        gen_pin_zero <= 1'b0;
        gen_pin_two <= 1'b1;
        settle();
        `CHK("ref_gpio pin two", 1'b1, pll_ref_gpio)
        `CHK("ref_mute pin two", 1'b0, pll_ref_mute)
        wr(pdc_pkg::OFS_REF_GPIO_SEL, 8'h00);
    endtask : test_ref_mux

    // boundary codes of p, j, r and the prohibited ones
    task automatic test_pjr();
        wr(pdc_pkg::OFS_P_DIVIDER, 8'h0E);
        wr(pdc_pkg::OFS_J_MULT, 8'h3F);
        wr(pdc_pkg::OFS_R_MULT, 8'h0F);
        settle();
        chk_cfg(5'h0F, 6'h3F, 14'h0000, 5'h10, 1'b0);
        wr(pdc_pkg::OFS_J_MULT, 8'h01);
        wr(pdc_pkg::OFS_P_DIVIDER, 8'h0F);
        settle();
        chk_cfg(5'h10, 6'h01, 14'h0000, 5'h10, 1'b1);
        wr(pdc_pkg::OFS_P_DIVIDER, 8'h00);
        wr(pdc_pkg::OFS_J_MULT, 8'h00);
        settle();
        chk_cfg(5'h01, 6'h00, 14'h0000, 5'h10, 1'b1);
        wr(pdc_pkg::OFS_J_MULT, 8'h3F);
    endtask : test_pjr

    // d applies only once both halves are written, in either order
    task automatic test_frac();
        wr(pdc_pkg::OFS_D_FRAC_HIGH, 8'h27);
        settle();
        chk_cfg(5'h01, 6'h3F, 14'h0000, 5'h10, 1'b0);
        wr(pdc_pkg::OFS_D_FRAC_LOW, 8'h0F);
        settle();
        chk_cfg(5'h01, 6'h3F, 14'h270F, 5'h10, 1'b0);
        wr(pdc_pkg::OFS_D_FRAC_LOW, 8'h10);
        rd(pdc_pkg::OFS_D_FRAC_LOW, rv);
        `CHK("staged low half", 8'h10, rv)
        chk_cfg(5'h01, 6'h3F, 14'h270F, 5'h10, 1'b0);
        wr(pdc_pkg::OFS_D_FRAC_HIGH, 8'h27);
        settle();
        chk_cfg(5'h01, 6'h3F, 14'h2710, 5'h10, 1'b1);
    endtask : test_frac

    // divided pulses in a window of steady source pulses
    task automatic dsp_window(input int n, input int exp_ticks);
        dsp_src_en <= 1'b1;
        repeat (300) @(posedge sys_clk);
        #1 tick_cnt = 0;
        repeat (n) @(posedge sys_clk);
        #1;
        `CHK("dsp ticks", exp_ticks, tick_cnt)
        @(posedge sys_clk);
        dsp_src_en <= 1'b0;
    endtask : dsp_window
    task automatic test_dsp();
        wr(pdc_pkg::OFS_DSP_CLK_DIV, 8'h00);
        dsp_window(12, 12);
        wr(pdc_pkg::OFS_DSP_CLK_DIV, 8'h02);
        dsp_window(12, 4);
        wr(pdc_pkg::OFS_DSP_CLK_DIV, 8'h7F);
        dsp_window(256, 2);
    endtask : test_dsp

    // auto mode overrides the programmed p, j, d, r and dsp divider
    task automatic test_auto();
        auto_cfg <= '{p_code: 4'h2, j_code: 6'h0A, d: 14'h0005, r_code: 4'h1, dsp_code: 7'h03};
        auto_mode <= 1'b1;
        settle();
        chk_cfg(5'h03, 6'h0A, 14'h0005, 5'h02, 1'b0);
        dsp_window(12, 3);
        auto_mode <= 1'b0;
        settle();
        chk_cfg(5'h01, 6'h3F, 14'h2710, 5'h10, 1'b1);
    endtask : test_auto

    // reset, then the scenarios in turn
    initial begin
        {rst, reg_wr, reg_rd, auto_mode, gen_pin_zero, gen_pin_two, dsp_src_en} = 7'h40;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        auto_cfg = '0;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        settle();
        test_regs();
        test_ref_mux();
        test_pjr();
        test_frac();
        test_dsp();
        test_auto();
        print_verdict();
    end
endmodule : pdc_pll_config_tb
`default_nettype wire
